/* File: hw/sgs_status_regs.sv */
// Sticky general status register bank read and cleared by SPI frames.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Reserved bits always read back as zero.
// - Supply A bit 6 latches on battery undervoltage.
// - Supply A bits 4,3,2 latch third regulator overcurrent, UV, overtemp.
// - Supply A bit 1 primary overvoltage, bit 0 primary prewarning.
// - Power-on flag is one after power-on, zero after soft reset.
// - Supply B bits 6,5 latch high-side supply under and overvoltage.
// - Supply B bits 4,3 latch secondary regulator overtemp and undervoltage.
// - Supply B bit 2 latches when primary stays below reset over 4ms.
// - Supply B bit 1 latches on fail-safe after fourth undervoltage reset.
// - Primary undervoltage flag updates only in permitted modes or short.
// - In sleep with primary off, primary short/over/undervoltage flags never set.
// - Thermal bit 2 latches on level-2 shutdown and requests fail-safe.
// - Thermal bit 1 latches level-1 shutdown, bit 0 prewarning.
// - Thermal flags stay set until explicitly cleared.
// - Prior-state field reads 00 cleared, 01 after failure, 10 from sleep.
// - Watchdog failure counter is hardware updated and never reaches 11.
// - Device status bit 1 latches on invalid serial command.
// - Device status bit 0 latches when a failure activates fail output.
// - Command bit 7 zero reads, one clears clearable bits of that byte.
// - A frame is address, access bit and one data byte.
// - Only the watchdog counter self-clears; flags need host clears.
// - Counter clears on good trigger or watchdog stop not due to failure.
module sgs_status_regs #(
  parameter int SC_CYC = sgs_pkg::SC_CYCLES
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              soft_reset,
  input  wire sgs_pkg::sgs_mode_e mode,
  input  wire logic              reset_output_released,
  input  wire logic              primary_reg_on,
  input  wire sgs_pkg::sgs_evt_s evt_async,
  input  wire logic              enter_restart_fail,
  input  wire logic              enter_restart_sleep,
  input  wire logic              watchdog_failure_counter_evt,
  input  wire logic              watchdog_failure_counter_two_step,
  input  wire logic              wd_trigger_ok,
  input  wire logic              wd_stop_no_fail,
  input  wire sgs_pkg::sgs_cmd_s cmd,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   failsafe_req
);
  sgs_pkg::sgs_evt_s evt_m;
  sgs_pkg::sgs_evt_s evt;
  logic [7:0]  sup_a_r;
  logic [7:0]  sup_b_r;
  logic [7:0]  therm_r;
  logic [7:0]  dev_r;
  logic [31:0] sc_cnt_r;
  logic        sc_hit;
  logic        sleep_off;
  logic        uv_ok;
  logic        rel_seen_r;
  logic [1:0]  wd_cnt;

  function automatic logic [7:0] sticky(input logic [7:0] cur,
                                        input logic [7:0] set,
                                        input logic       clr,
                                        input logic [7:0] cmask);
    logic [7:0] v;
    v = clr ? (cur & ~cmask) : cur;
    return v | set;
  endfunction

  function automatic logic hit(input sgs_pkg::sgs_cmd_s c,
                               input logic [6:0] a);
    return c.valid && c.clear && (c.addr == a);
  endfunction

  // Monitor levels come from the analog domain and are synchronised first.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_m <= '0;
      evt   <= '0;
    end else if (clk_en) begin
      evt_m <= evt_async;
      evt   <= evt_m;
    end
  end

  // Counts how long the primary regulator stays below its reset threshold.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sc_cnt_r <= '0;
    end else if (clk_en) begin
      if (!evt.r1_below_rst || !primary_reg_on) begin
        sc_cnt_r <= '0;
      end else if (sc_cnt_r < 32'(SC_CYC)) begin
        sc_cnt_r <= sc_cnt_r + 32'h1;
      end
    end
  end
  assign sc_hit = (sc_cnt_r >= 32'(SC_CYC));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rel_seen_r <= 1'b0;
    end else if (clk_en) begin
      if (soft_reset) begin
        rel_seen_r <= 1'b0;
      end else if (reset_output_released) begin
        rel_seen_r <= 1'b1;
      end
    end
  end

  assign sleep_off = (mode == sgs_pkg::SGS_SLEEP) && !primary_reg_on;
  // Restart updates only on sc_hit; init waits for first release of the reset output.
  assign uv_ok = sc_hit ||
                 (mode == sgs_pkg::SGS_NORMAL) ||
                 (mode == sgs_pkg::SGS_STOP) ||
                 ((mode == sgs_pkg::SGS_INIT) && rel_seen_r);

  // Set wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sup_a_r <= sgs_pkg::RST_SUP_A;
    end else if (clk_en) begin
      if (soft_reset) begin
        sup_a_r <= sgs_pkg::RST_SUP_A;
      end else begin
        sup_a_r <= sticky(sup_a_r,
          {1'b0, evt.batt_uv, 1'b0, evt.r3_oc, evt.r3_uv, evt.r3_ot,
           evt.r1_ov && !sleep_off, evt.r1_warn},
          hit(cmd, sgs_pkg::ADDR_SUP_A),
          sgs_pkg::MASK_SUP_A);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sup_b_r <= sgs_pkg::RST_SUP_B_POR;
    end else if (clk_en) begin
      if (soft_reset) begin
        sup_b_r <= sgs_pkg::RST_SUP_B_SOFT;
      end else begin
        sup_b_r <= sticky(sup_b_r,
          {1'b0, evt.hs_uv, evt.hs_ov, evt.r2_ot, evt.r2_uv,
           sc_hit && !sleep_off, evt.r1_uv_fs,
           evt.r1_uv && uv_ok && !sleep_off},
          hit(cmd, sgs_pkg::ADDR_SUP_B),
          sgs_pkg::MASK_SUP_B);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      therm_r <= sgs_pkg::RST_THERM;
    end else if (clk_en) begin
      if (soft_reset) begin
        therm_r <= sgs_pkg::RST_THERM;
      end else begin
        therm_r <= sticky(therm_r,
          {5'h00, evt.thermal_shutdown_level2_flag, evt.thermal_shutdown_level1_flag, evt.thermal_prewarning_flag},
          hit(cmd, sgs_pkg::ADDR_THERM),
          sgs_pkg::MASK_THERM);
      end
    end
  end

  // Level-2 shutdown forces fail-safe; held as a pulse-free level request.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      failsafe_req <= 1'b0;
    end else if (clk_en) begin
      failsafe_req <= evt.thermal_shutdown_level2_flag || evt.r1_uv_fs;
    end
  end

  assign wd_cnt = dev_r[sgs_pkg::POS_WDCNT +: 2];

  // Counter stops at one, or at two when watchdog_failure_counter_two_step is set, so the reserved code is never produced.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dev_r <= sgs_pkg::RST_DEV;
    end else if (clk_en) begin
      if (soft_reset) begin
        dev_r <= sgs_pkg::RST_DEV;
      end else begin
        dev_r <= sticky(dev_r, {6'h00, evt.spi_invalid, evt.fail_out},
          hit(cmd, sgs_pkg::ADDR_DEV), sgs_pkg::CLR_DEV);
        if (enter_restart_fail) begin
          dev_r[sgs_pkg::POS_PRIOR +: 2] <= sgs_pkg::PRIOR_FAIL;
        end else if (enter_restart_sleep) begin
          dev_r[sgs_pkg::POS_PRIOR +: 2] <= sgs_pkg::PRIOR_SLEEP;
        end
        if (wd_trigger_ok || wd_stop_no_fail) begin
          dev_r[sgs_pkg::POS_WDCNT +: 2] <= 2'h0;
        end else if (watchdog_failure_counter_evt && wd_cnt == 2'h0) begin
          dev_r[sgs_pkg::POS_WDCNT +: 2] <= 2'h1;
        end else if (watchdog_failure_counter_evt && wd_cnt == 2'h1 && watchdog_failure_counter_two_step) begin
          dev_r[sgs_pkg::POS_WDCNT +: 2] <= 2'h2;
        end
      end
    end
  end

  // Read data are captured from the value held before any clear.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= cmd.valid;
      unique case (cmd.addr)
        sgs_pkg::ADDR_SUP_A: rd_data <= sup_a_r & sgs_pkg::MASK_SUP_A;
        sgs_pkg::ADDR_SUP_B: rd_data <= sup_b_r;
        sgs_pkg::ADDR_THERM: rd_data <= therm_r & sgs_pkg::MASK_THERM;
        sgs_pkg::ADDR_DEV:   rd_data <= dev_r & sgs_pkg::MASK_DEV;
        default:             rd_data <= 8'h00;
      endcase
    end
  end

  a_therm_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && therm_r[2] && !soft_reset && !hit(cmd, sgs_pkg::ADDR_THERM)
    |=> therm_r[2]) else $error("thermal flag dropped");
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (sup_a_r[7] == 1'b0) && (sup_a_r[5] == 1'b0) && (therm_r[7:3] == 5'h00)
    && (dev_r[5:4] == 2'h0)) else $error("reserved bit set");
  a_wd_never3: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wd_cnt != 2'h3) else $error("watchdog count reached three");
  a_wd_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !soft_reset && wd_trigger_ok |=> wd_cnt == 2'h0)
    else $error("watchdog count not cleared");
  a_uv_restart: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !soft_reset && mode == sgs_pkg::SGS_RESTART && !sc_hit &&
    !sup_b_r[0] |=> !sup_b_r[0]) else $error("uv set in restart");
  a_sleep_sc: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !soft_reset && sleep_off && !sup_b_r[2] |=> !sup_b_r[2])
    else $error("short set in sleep");
  a_spi_latch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !soft_reset && evt.spi_invalid |=> dev_r[1])
    else $error("invalid command not latched");
  a_clear_wd_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !soft_reset && hit(cmd, sgs_pkg::ADDR_DEV) && !watchdog_failure_counter_evt &&
    !wd_trigger_ok && !wd_stop_no_fail |=> $stable(wd_cnt))
    else $error("clear touched counter");
  a_soft_por: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && soft_reset |=> sup_b_r == 8'h00)
    else $error("soft reset left flags");
  a_thermal_shutdown_level2_flag_fs: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && evt.thermal_shutdown_level2_flag |=> failsafe_req)
    else $error("no fail-safe request");
endmodule
`default_nettype wire

/* File: common/sgs_pkg.sv */
// Package with register map, field positions and timing for the status bank.
package sgs_pkg;
  localparam logic [6:0] ADDR_SUP_A  = 7'h40;
  localparam logic [6:0] ADDR_SUP_B  = 7'h41;
  localparam logic [6:0] ADDR_THERM  = 7'h42;
  localparam logic [6:0] ADDR_DEV    = 7'h43;
  localparam logic [7:0] RST_SUP_A   = 8'h00;
  localparam logic [7:0] RST_SUP_B_POR  = 8'h80;
  localparam logic [7:0] RST_SUP_B_SOFT = 8'h00;
  localparam logic [7:0] RST_THERM   = 8'h00;
  localparam logic [7:0] RST_DEV     = 8'h00;
  localparam logic [7:0] MASK_SUP_A  = 8'h5F;
  localparam logic [7:0] MASK_SUP_B  = 8'hFF;
  localparam logic [7:0] MASK_THERM  = 8'h07;
  localparam logic [7:0] MASK_DEV    = 8'hCF;
  localparam logic [7:0] CLR_DEV     = 8'hC3;
  localparam int         POS_PRIOR   = 6;
  localparam int         POS_WDCNT   = 2;
  localparam logic [1:0] PRIOR_FAIL  = 2'h1;
  localparam logic [1:0] PRIOR_SLEEP = 2'h2;
  localparam int         SC_TIME_MS  = 4;
  localparam int         CLK_HZ      = 25000000;
  localparam int         SC_CYCLES   = SC_TIME_MS * (CLK_HZ / 1000);
  typedef enum logic [2:0] {
    SGS_INIT    = 3'h0,
    SGS_NORMAL  = 3'h1,
    SGS_STOP    = 3'h3,
    SGS_SLEEP   = 3'h2,
    SGS_RESTART = 3'h6,
    SGS_FSAFE   = 3'h7
  } sgs_mode_e;
  typedef struct packed {
    logic batt_uv;
    logic r3_oc;
    logic r3_uv;
    logic r3_ot;
    logic r1_ov;
    logic r1_warn;
    logic hs_uv;
    logic hs_ov;
    logic r2_ot;
    logic r2_uv;
    logic r1_below_rst;
    logic r1_uv_fs;
    logic r1_uv;
    logic thermal_shutdown_level2_flag;
    logic thermal_shutdown_level1_flag;
    logic thermal_prewarning_flag;
    logic spi_invalid;
    logic fail_out;
  } sgs_evt_s;
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic       clear;
  } sgs_cmd_s;
endpackage

/* File: bench/sgs_host_model.sv */
// Host model that issues decoded register frames to the status bank.
`timescale 1ns/10ps
`default_nettype none
module sgs_host_model (
  input  wire logic            ref_clk,
  input  wire logic [7:0]      rd_data,
  input  wire logic            rd_valid,
  output var sgs_pkg::sgs_cmd_s cmd
);
  initial cmd = '0;
  // Address and access bit go out together; one data byte comes back.
  task automatic access(input logic [6:0] a, input logic c,
                        output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    cmd <= '{valid: 1'b1, addr: a, clear: c};
    @(posedge ref_clk);
    // Released lines show inverted values so stale data cannot match.
    cmd <= '{valid: 1'b0, addr: ~a, clear: ~c};
    #1;
    ok = rd_valid;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the sticky status register bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic               ref_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               clk_en = 1'b1;
  logic               two = 1'b0;
  logic               on = 1'b1;
  logic [6:0]         pls = '0;
  sgs_pkg::sgs_mode_e mode = sgs_pkg::SGS_NORMAL;
  sgs_pkg::sgs_evt_s  evt = '0;
  sgs_pkg::sgs_cmd_s  cmd;
  logic [7:0]         rd_data, d;
  logic [7:0]         ex [4];
  logic               rd_valid, fs_req, ok;
  logic [19:0]        lf = 20'h12380;
  logic [17:0]        e;
  logic [4:0]         v;
  int                 miscompares = 0;
  int                 samples_checked = 0;

  always #20 ref_clk = ~ref_clk;

  sgs_status_regs #(.SC_CYC(8)) i_sgs_status_regs (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .soft_reset(pls[0]), .mode(mode), .reset_output_released(pls[6]),
    .primary_reg_on(on), .evt_async(evt), .enter_restart_fail(pls[5]),
    .enter_restart_sleep(pls[4]), .watchdog_failure_counter_evt(pls[3]),
    .watchdog_failure_counter_two_step(two), .wd_trigger_ok(pls[2]),
    .wd_stop_no_fail(pls[1]), .cmd(cmd), .rd_data(rd_data),
    .rd_valid(rd_valid), .failsafe_req(fs_req));

  sgs_host_model i_sgs_host_model (
    .ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd));

  function automatic logic [19:0] nx(input logic [19:0] s);
    return {s[18:0], s[19] ^ s[16]};
  endfunction

  // Register index and bit position of each monitor in the event struct.
  function automatic logic [4:0] loc(input int i);
    if (i >= 12) return {2'h0, (i == 17) ? 3'h6 : 3'(i - 12)};
    if (i >= 5) return {2'h1, 3'(i - 5)};
    if (i >= 2) return {2'h2, 3'(i - 2)};
    return {2'h3, 3'(i)};
  endfunction

  task automatic cmp(input string nm, input logic [7:0] x,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic rd(input int r, input logic c, input logic [7:0] x);
    i_sgs_host_model.access(sgs_pkg::ADDR_SUP_A + 7'(r), c, d, ok);
    cmp("rd_valid", 8'h01, {7'h00, ok});
    cmp($sformatf("register %0d", r), x, d);
  endtask

  // Monitor levels are held long enough to pass the two-flop synchroniser.
  task automatic ev(input logic [17:0] p, input int n,
                    input sgs_pkg::sgs_mode_e m, input logic o);
    @(posedge ref_clk);
    evt <= p;
    mode <= m;
    on <= o;
    repeat (n) @(posedge ref_clk);
    evt <= '0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pulse(input logic [6:0] p);
    @(posedge ref_clk);
    pls <= p;
    @(posedge ref_clk);
    pls <= '0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(1, 1'b1, sgs_pkg::RST_SUP_B_POR);
    for (int r = 0; r < 5; r++) rd(r, 1'b1, 8'h00);
    pulse(7'h40);
    ex = '{default: 8'h00};
    // Sparse random monitor patterns; the short monitor needs a long hold.
    for (int k = 0; k < 12; k++) begin
      lf = nx(nx(lf));
      e = lf[17:0] & lf[19:2] & 18'h3FF7F;
      for (int i = 0; i < 18; i++) begin
        v = loc(i);
        if (e[i]) ex[v[4:3]][v[2:0]] = 1'b1;
      end
      ev(e, 3, sgs_pkg::SGS_NORMAL, 1'b1);
    end
    for (int r = 0; r < 4; r++) rd(r, 1'b0, ex[r]);
    rd(0, 1'b1, ex[0]);
    rd(1, 1'b1, ex[1]);
    rd(2, 1'b1, ex[2]);
    rd(3, 1'b1, ex[3]);
    for (int r = 0; r < 4; r++) rd(r, 1'b0, 8'h00);
    ev(18'h00080, 4, sgs_pkg::SGS_NORMAL, 1'b1);
    rd(1, 1'b1, 8'h00);
    ev(18'h00080, 14, sgs_pkg::SGS_NORMAL, 1'b1);
    rd(1, 1'b1, 8'h04);
    @(posedge ref_clk);
    evt <= 18'h00010;
    repeat (5) @(posedge ref_clk);
    #1 cmp("failsafe_req", 8'h01, {7'h00, fs_req});
    ev(18'h00000, 1, sgs_pkg::SGS_NORMAL, 1'b1);
    rd(2, 1'b1, 8'h04);
    ev(18'h00020, 3, sgs_pkg::SGS_RESTART, 1'b1);
    rd(1, 1'b1, 8'h00);
    ev(18'h020A0, 14, sgs_pkg::SGS_SLEEP, 1'b0);
    rd(0, 1'b1, 8'h00);
    rd(1, 1'b1, 8'h00);
    pulse(7'h10);
    rd(3, 1'b1, 8'h80);
    rd(3, 1'b0, 8'h00);
    pulse(7'h30);
    rd(3, 1'b1, 8'h40);
    pulse(7'h08);
    pulse(7'h08);
    rd(3, 1'b1, 8'h04);
    rd(3, 1'b0, 8'h04);
    pulse(7'h04);
    rd(3, 1'b0, 8'h00);
    two <= 1'b1;
    for (int k = 0; k < 3; k++) pulse(7'h08);
    rd(3, 1'b0, 8'h08);
    pulse(7'h02);
    rd(3, 1'b0, 8'h00);
    // A failure pulse while the enable is low must leave the counter alone.
    clk_en <= 1'b0;
    pulse(7'h08);
    clk_en <= 1'b1;
    rd(3, 1'b0, 8'h00);
    pulse(7'h01);
    rd(1, 1'b0, sgs_pkg::RST_SUP_B_SOFT);
    ev(18'h00020, 3, sgs_pkg::SGS_INIT, 1'b1);
    rd(1, 1'b1, 8'h00);
    pulse(7'h40);
    ev(18'h00020, 3, sgs_pkg::SGS_INIT, 1'b1);
    rd(1, 1'b1, 8'h01);
    ev(18'h00020, 3, sgs_pkg::SGS_STOP, 1'b1);
    rd(1, 1'b1, 8'h01);
    give_verdict();
  end
endmodule
`default_nettype wire
